// ===== pcsr_addr_dec.sv
// address decoder that finds the pcs word in either map
module pcsr_addr_dec
  import pcsr_pkg::*;
(
  input wire logic [9:0] addr,
  input wire logic combined_map,
  input wire logic byte_addressing,
  output logic hit,
  output logic [4:0] word
);

  // byte address to dword, low lanes dropped
  wire [9:0] dword_addr;
  // byte access must land on a dword boundary
  wire aligned;
  // hit test in each map
  wire shared_hit;
  wire alone_hit;

  // byte to dword by dividing by four
  assign dword_addr = byte_addressing ?
    {2'b00, addr[9:BYTE_LANE_BITS]} : addr;
  assign aligned = ~byte_addressing | (addr[1:0] == 2'b00);
  // pcs window sits at dword base onward
  assign shared_hit = aligned &
    (dword_addr[9:5] == PCS_DWORD_BASE[9:5]);
  // standalone: address is the word offset itself
  assign alone_hit = (addr[9:5] == 5'h00);
  assign hit = combined_map ? shared_hit : alone_hit;
  assign word = combined_map ? dword_addr[4:0] : addr[4:0];

endmodule

// ===== pcsr_host.sv
// behavioural host master for the pcs register bank
module pcsr_host
  import pcsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic combined_map,
  input wire logic byte_addressing,
  input wire pcsr_pkg::pcsr_rsp_t bus_rsp,
  output pcsr_pkg::pcsr_req_t bus_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus idle at start
  initial bus_req = '0;
  // one access by word offset, address formed per map mode
  task automatic acc(input logic w, input logic [4:0] off,
    input logic [15:0] d, output logic rv, output logic [31:0] q);
    logic [9:0] a;
    a = {5'h00, off};
    if (combined_map) begin
      a = PCS_DWORD_BASE + a;
      if (byte_addressing) begin
        a = a << 2;
      end
    end
    @(posedge sys_clk);
    #1;
    bus_req = '{rd: !w, wr: w, addr: a, wdata: {16'h0000, d}};
    @(posedge sys_clk);
    #1;
    rv = bus_rsp.rvalid;
    q = bus_rsp.rdata;
    // released: address and data inverted, not held
    bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~bus_req.wdata};
  endtask
endmodule

// ===== pcsr_pkg.sv
// constants and carrier types of the pcs register bank
package pcsr_pkg;

  // bus and register widths
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int WORD_W = 5;

  // word offsets inside the pcs window
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h01;
  localparam logic [4:0] OFS_IDENT_UPPER = 5'h02;
  localparam logic [4:0] OFS_IDENT_LOWER = 5'h03;
  localparam logic [4:0] OFS_LOCAL_ADV = 5'h04;
  localparam logic [4:0] OFS_REMOTE_ADV = 5'h05;
  localparam logic [4:0] OFS_EXPANSION = 5'h06;
  localparam logic [4:0] OFS_UNSUP_FIRST = 5'h07;
  localparam logic [4:0] OFS_UNSUP_LAST = 5'h0a;
  localparam logic [4:0] OFS_RSVD_FIRST = 5'h0b;
  localparam logic [4:0] OFS_RSVD_LAST = 5'h0e;
  localparam logic [4:0] OFS_IF_MODE = 5'h14;

  // placement of the pcs window in the shared map
  localparam logic [9:0] PCS_DWORD_BASE = 10'h080;
  localparam int BYTE_LANE_BITS = 2;

  // reset values
  localparam logic [15:0] RST_CONTROL = 16'h1140;
  localparam logic [15:0] RST_STATUS = 16'h0089;
  localparam logic [15:0] RST_LOCAL_ADV = 16'h01a0;
  localparam logic [15:0] RST_REMOTE_ADV = 16'h0000;
  localparam logic [15:0] RST_EXPANSION = 16'h0000;
  localparam logic [15:0] RST_IF_MODE = 16'h0000;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // writable bits of each read-write word
  localparam logic [15:0] MASK_CONTROL = 16'h9e20;
  localparam logic [15:0] MASK_LOCAL_ADV = 16'hffff;
  localparam logic [15:0] MASK_IF_MODE = 16'h0003;

  // interface mode fields
  localparam int IF_MODE_SGMII_BIT = 0;
  localparam int IF_MODE_PHY_BIT = 1;

  // word advertised in sgmii mac mode instead of local abilities
  localparam logic [15:0] SGMII_MAC_ADV = 16'h4001;

  // one bus request from the host
  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [31:0] wdata;
  } pcsr_req_t;

  // answer to the host
  typedef struct packed {
    logic sel;
    logic waitrequest;
    logic rvalid;
    logic [31:0] rdata;
  } pcsr_rsp_t;

  // state reported by the pcs core
  typedef struct packed {
    logic [15:0] status;
    logic [15:0] expansion;
    logic [15:0] rx_page;
    logic rx_page_valid;
  } pcsr_core_t;

  // settings driven into the pcs core
  typedef struct packed {
    logic [15:0] control;
    logic [15:0] adv_word;
    logic sgmii_en;
    logic sgmii_mac;
  } pcsr_cfg_t;

endpackage

// ===== pcsr_regs.sv
// pcs configuration and status register bank
module pcsr_regs
  import pcsr_pkg::*;
#(
  // identifier value, arbitrary default
  parameter logic [31:0] LINK_IDENTITY_PARAMETER = 32'h1234_5678
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic combined_map,
  input wire logic byte_addressing,
  input wire pcsr_pkg::pcsr_req_t bus_req,
  output pcsr_pkg::pcsr_rsp_t bus_rsp,
  input wire pcsr_pkg::pcsr_core_t core_in,
  output pcsr_pkg::pcsr_cfg_t cfg_out
);

  import pcsr_pkg::*;

  // address decode
  // both maps end in one 5-bit word offset
  // so the bank behind it sees a single layout

  // request lands in the pcs window
  logic hit;
  // word offset inside the window
  logic [4:0] word;

  // map the bus address to a pcs word
  pcsr_addr_dec u_addr_dec (
    .addr(bus_req.addr),
    .combined_map(combined_map),
    .byte_addressing(byte_addressing),
    .hit(hit),
    .word(word)
  );

  // qualified read and write strobes
  wire rd_hit;
  wire wr_hit;

  // a write wins if both strobes are set
  assign wr_hit = bus_req.wr & hit;
  assign rd_hit = bus_req.rd & ~bus_req.wr & hit;

  // per-word write enables
  wire wr_control;
  wire wr_local_adv;
  wire wr_if_mode;

  // only read-write words see a write enable
  assign wr_control = wr_hit & (word == OFS_CONTROL);
  assign wr_local_adv = wr_hit & (word == OFS_LOCAL_ADV);
  assign wr_if_mode = wr_hit & (word == OFS_IF_MODE);

  // read-only and unused words get no enable
  // so a write to them is simply dropped
  // while the bus still completes normally

  // only the low lanes carry register data
  wire [15:0] wdata_low;

  // upper write lanes are dropped
  assign wdata_low = bus_req.wdata[15:0];

  // read-write words
  // each is a masked register with its own reset
  // bits outside the mask keep their reset value

  // control word as stored
  logic [15:0] control;
  // local advertised abilities
  logic [15:0] local_adv;
  // interface mode selection
  logic [15:0] if_mode;

  // control, fixed bits held by mask
  pcsr_rw_word #(
    .RESET_VALUE(RST_CONTROL),
    .WRITE_MASK(MASK_CONTROL)
  ) u_control (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(wr_control),
    .wdata(wdata_low),
    .q(control)
  );

  // abilities sent to the partner
  pcsr_rw_word #(
    .RESET_VALUE(RST_LOCAL_ADV),
    .WRITE_MASK(MASK_LOCAL_ADV)
  ) u_local_adv (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(wr_local_adv),
    .wdata(wdata_low),
    .q(local_adv)
  );

  // base-x versus sgmii choice
  pcsr_rw_word #(
    .RESET_VALUE(RST_IF_MODE),
    .WRITE_MASK(MASK_IF_MODE)
  ) u_if_mode (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(wr_if_mode),
    .wdata(wdata_low),
    .q(if_mode)
  );

  // read-only words fed by the core
  // the bus has no write path into these
  // they change only through core_in

  // latest status from the core
  logic [15:0] status;
  // abilities the partner sent
  logic [15:0] remote_adv;
  // expansion status from the core
  logic [15:0] expansion;

  // status follows the core each cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // reset value until the core reports
      status <= RST_STATUS;
    end else begin
      // copy the core every cycle
      status <= core_in.status;
    end
  end

  // partner page caught when the core has one
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // nothing received yet
      remote_adv <= RST_REMOTE_ADV;
    end else if (core_in.rx_page_valid) begin
      // held until the next page arrives
      remote_adv <= core_in.rx_page;
    end
  end

  // expansion follows the core each cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // cleared until the core reports
      expansion <= RST_EXPANSION;
    end else begin
      // copy the core every cycle
      expansion <= core_in.expansion;
    end
  end

  // bus writes never reach these three words
  // so a write to them changes nothing

  // read selection
  // one mux for every word of the window
  // anything not named below reads as zero

  // identifier halves
  wire [15:0] ident_upper;
  wire [15:0] ident_lower;

  // build-time identifier split in two
  assign ident_upper = LINK_IDENTITY_PARAMETER[31:16];
  assign ident_lower = LINK_IDENTITY_PARAMETER[15:0];

  // true when a word offset lies in a closed range
  // shared by both zero-reading ranges below
  function automatic logic word_in_range(
    input logic [4:0] w,
    input logic [4:0] lo,
    input logic [4:0] hi
  );
    word_in_range = (w >= lo) & (w <= hi);
  endfunction

  // word range tests
  wire in_unsup;
  wire in_rsvd;

  // unsupported next-page and clock-role words
  assign in_unsup = word_in_range(word, OFS_UNSUP_FIRST,
    OFS_UNSUP_LAST);
  // reserved words
  assign in_rsvd = word_in_range(word, OFS_RSVD_FIRST,
    OFS_RSVD_LAST);

  // selected 16-bit read value
  logic [15:0] rd_word;

  // pick the word, everything else reads zero
  always_comb begin
    rd_word = READ_ZERO;
    case (word)
      OFS_CONTROL: begin
        // stored control word
        rd_word = control;
      end
      OFS_STATUS: begin
        // core status as last sampled
        rd_word = status;
      end
      OFS_IDENT_UPPER: begin
        // upper identifier half
        rd_word = ident_upper;
      end
      OFS_IDENT_LOWER: begin
        // lower identifier half
        rd_word = ident_lower;
      end
      OFS_LOCAL_ADV: begin
        // abilities we advertise
        rd_word = local_adv;
      end
      OFS_REMOTE_ADV: begin
        // last page from the partner
        rd_word = remote_adv;
      end
      OFS_EXPANSION: begin
        // expansion as last sampled
        rd_word = expansion;
      end
      OFS_IF_MODE: begin
        // interface mode selection
        rd_word = if_mode;
      end
      default: begin
        // unsupported, reserved and unmapped
        rd_word = READ_ZERO;
      end
    endcase
  end

  // words with no storage behind them
  wire zero_word;

  // these words have no storage at all
  assign zero_word = in_unsup | in_rsvd;

  // bus answer
  // reads answer one cycle later from a register
  // writes need no answer and never wait

  // registered read data and its strobe
  logic [15:0] rdata_low;
  logic rvalid;

  // read data one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // nothing to show after reset
      rdata_low <= READ_ZERO;
      rvalid <= 1'b0;
    end else begin
      // strobe marks the cycle after each read hit
      rvalid <= rd_hit;
      // data holds between reads
      if (rd_hit) begin
        rdata_low <= zero_word ? READ_ZERO : rd_word;
      end
    end
  end

  // writes always finish in the request cycle
  wire stall;

  // no access type ever holds the host
  assign stall = 1'b0;

  // upper half always reads zero
  assign bus_rsp.rdata = {16'h0000, rdata_low};
  assign bus_rsp.rvalid = rvalid;
  // tells a shared decoder this slave answers
  assign bus_rsp.sel = hit;
  assign bus_rsp.waitrequest = stall;

  // settings for the core
  // mode flags decoded from the mode word
  // then registered before they leave

  // mode flags from the mode word
  wire sgmii_en;
  wire sgmii_mac;

  // sgmii on, and mac side when phy bit clear
  assign sgmii_en = if_mode[IF_MODE_SGMII_BIT];
  assign sgmii_mac = sgmii_en &
    ~if_mode[IF_MODE_PHY_BIT];

  // mac side sends fixed word, not local abilities
  wire [15:0] adv_word;

  assign adv_word = sgmii_mac ? SGMII_MAC_ADV : local_adv;

  // registered copies of the derived settings
  // flags and advertised word move together
  // so the core never sees a half-changed mode
  logic cfg_sgmii_en;
  logic cfg_sgmii_mac;
  logic [15:0] cfg_adv_word;

  // settings register, one cycle behind the mode word
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // power-up mode taken from the mode word reset
      cfg_sgmii_en <= RST_IF_MODE[IF_MODE_SGMII_BIT];
      cfg_sgmii_mac <= RST_IF_MODE[IF_MODE_SGMII_BIT] &
        ~RST_IF_MODE[IF_MODE_PHY_BIT];
      cfg_adv_word <= RST_LOCAL_ADV;
    end else begin
      // follow the mode word and abilities
      cfg_sgmii_en <= sgmii_en;
      cfg_sgmii_mac <= sgmii_mac;
      cfg_adv_word <= adv_word;
    end
  end

  // control is a flip-flop already, sent as it is
  assign cfg_out.control = control;
  assign cfg_out.adv_word = cfg_adv_word;
  assign cfg_out.sgmii_en = cfg_sgmii_en;
  assign cfg_out.sgmii_mac = cfg_sgmii_mac;

endmodule

// ===== pcsr_regs_asserts.sv
// port checker for the pcs register bank
module pcsr_regs_asserts
  import pcsr_pkg::*;
#(
  parameter logic [31:0] LINK_IDENTITY_PARAMETER = 32'h0000_0000
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic combined_map,
  input wire logic byte_addressing,
  input wire pcsr_pkg::pcsr_req_t bus_req,
  input wire pcsr_pkg::pcsr_rsp_t bus_rsp,
  input wire pcsr_pkg::pcsr_core_t core_in,
  input wire pcsr_pkg::pcsr_cfg_t cfg_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // standalone read of one word
  sequence s_rd(logic [9:0] a);
    bus_req.rd && !bus_req.wr && !combined_map && bus_req.addr == a;
  endsequence
  // any read that hits the window
  sequence s_take;
    bus_req.rd && !bus_req.wr && bus_rsp.sel;
  endsequence
  property p_upper_zero;
    bus_rsp.rvalid |-> bus_rsp.rdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper half not zero");
  property p_rd_answer;
    s_take |=> bus_rsp.rvalid && !bus_rsp.waitrequest;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  property p_word_map;
    combined_map && !byte_addressing && bus_req.addr == 10'h094
      |-> bus_rsp.sel;
  endproperty
  a_word_map: assert property (p_word_map)
    else $error("dword map miss");
  property p_byte_map;
    combined_map && byte_addressing |->
      ((bus_req.addr == 10'h250) ? bus_rsp.sel :
      (bus_req.addr[1:0] == 2'b00 || !bus_rsp.sel));
  endproperty
  a_byte_map: assert property (p_byte_map)
    else $error("byte map wrong");
  property p_ctrl_hold;
    !$past(bus_req.wr) |-> $stable(cfg_out.control);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control changed without write");
  property p_status;
    s_rd(10'h001) ##0 !$past(sys_rst)
      |=> bus_rsp.rdata[15:0] == $past(core_in.status, 2);
  endproperty
  a_status: assert property (p_status)
    else $error("status read wrong");
  property p_ident;
    (s_rd(10'h002) |=>
      bus_rsp.rdata[15:0] == LINK_IDENTITY_PARAMETER[31:16])
    and (s_rd(10'h003) |=>
      bus_rsp.rdata[15:0] == LINK_IDENTITY_PARAMETER[15:0]);
  endproperty
  a_ident: assert property (p_ident)
    else $error("identifier read wrong");
  property p_mac_adv;
    cfg_out.sgmii_mac && $past(cfg_out.sgmii_mac)
      |-> cfg_out.adv_word == 16'h4001;
  endproperty
  a_mac_adv: assert property (p_mac_adv)
    else $error("mac mode advertised local word");
  property p_zero_words;
    bus_req.rd && !bus_req.wr && !combined_map &&
      bus_req.addr inside {[10'h007:10'h00e]} |=> bus_rsp.rdata == 0;
  endproperty
  a_zero_words: assert property (p_zero_words)
    else $error("unused word not zero");
endmodule

// ===== pcsr_regs_tb.sv
// self-checking bench for the pcs register bank
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module pcsr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pcsr_pkg::*;
  // identifier value, arbitrary
  localparam logic [31:0] ID = 32'h0a5c_3e71;
  typedef struct {logic [4:0] off; logic [15:0] d; logic [15:0] e;} pcsr_row_t;
  logic sys_clk, sys_rst, combined_map, byte_addressing, rv;
  logic [31:0] q;
  pcsr_req_t bus_req;
  pcsr_rsp_t bus_rsp;
  pcsr_core_t core_in;
  pcsr_cfg_t cfg_out;
  int error_cnt, cmp_count, cyc;
  // write, readback expected
  pcsr_row_t rows[$] = '{'{0, 16'hffff, 16'h9f60}, '{1, 16'hffff, 16'h002c},
    '{2, 16'hffff, ID[31:16]}, '{3, 16'hffff, ID[15:0]},
    '{4, 16'h5a5a, 16'h5a5a}, '{5, 16'hffff, 16'h0000},
    '{6, 16'hffff, 16'h0006}, '{20, 16'hffff, 16'h0003}};
  pcsr_regs #(.LINK_IDENTITY_PARAMETER(ID)) i_pcsr_regs (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .combined_map(combined_map),
    .byte_addressing(byte_addressing), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .core_in(core_in), .cfg_out(cfg_out));
  pcsr_host i_pcsr_host (.sys_clk(sys_clk), .combined_map(combined_map),
    .byte_addressing(byte_addressing), .bus_rsp(bus_rsp), .bus_req(bus_req));
  // clock source
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic wr(logic [4:0] off, logic [15:0] d);
    i_pcsr_host.acc(1, off, d, rv, q);
  endtask
  task automatic rd_chk(string n, logic [4:0] off, logic [15:0] e);
    i_pcsr_host.acc(0, off, 16'h0000, rv, q);
    `CHK(n, {1'b1, 16'h0000, e}, {rv, q})
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    sys_rst = 1;
    combined_map = 0;
    byte_addressing = 0;
    core_in = '{16'h002c, 16'h0006, 16'h41a0, 1'b0};
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (5) @(posedge sys_clk);
    #1 sys_rst = 0;
    rd_chk("control", 0, 16'h1140);
    rd_chk("local", 4, 16'h01a0);
    rd_chk("remote", 5, 16'h0000);
    rd_chk("mode", 20, 16'h0000);
    $display("test reset done");
    for (int k = 7; k <= 14; k++) rows.push_back('{k, 16'hffff, 16'h0000});
    foreach (rows[i]) begin
      wr(rows[i].off, rows[i].d);
      rd_chk("row", rows[i].off, rows[i].e);
    end
    `CHK("sgmii", 1'b1, cfg_out.sgmii_en)
    `CHK("mac", 1'b0, cfg_out.sgmii_mac)
    $display("test rows done");
    combined_map = 1;
    wr(20, 16'h0001);
    rd_chk("dword", 20, 16'h0001);
    `CHK("adv", 16'h4001, cfg_out.adv_word)
    `CHK("mac", 1'b1, cfg_out.sgmii_mac)
    byte_addressing = 1;
    wr(20, 16'h0002);
    rd_chk("byte", 20, 16'h0002);
    `CHK("adv", 16'h5a5a, cfg_out.adv_word)
    `CHK("sgmii", 1'b0, cfg_out.sgmii_en)
    combined_map = 0;
    byte_addressing = 0;
    $display("test map done");
    core_in.rx_page_valid = 1;
    @(posedge sys_clk);
    #1 core_in.rx_page_valid = 0;
    rd_chk("remote", 5, 16'h41a0);
    wr(0, 16'h0000);
    rd_chk("control", 0, 16'h0140);
    `CHK("ctl out", 16'h0140, cfg_out.control)
    `CHK("stall", 1'b0, bus_rsp.waitrequest)
    sys_rst = 1;
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 0;
    rd_chk("control", 0, 16'h1140);
    rd_chk("local", 4, 16'h01a0);
    $display("test partner and reset done");
    close_out();
  end
endmodule
bind pcsr_regs pcsr_regs_asserts
  #(.LINK_IDENTITY_PARAMETER(LINK_IDENTITY_PARAMETER)) i_pcsr_regs_asserts (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .combined_map(combined_map),
  .byte_addressing(byte_addressing), .bus_req(bus_req),
  .bus_rsp(bus_rsp), .core_in(core_in), .cfg_out(cfg_out));

// ===== pcsr_rw_word.sv
// one 16-bit read-write word with reset value and write mask
module pcsr_rw_word
  import pcsr_pkg::*;
#(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK = 16'hffff
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  output logic [15:0] q
);

  // bits outside the write mask keep their reset value forever
  wire [15:0] next_q;

  assign next_q = (q & ~WRITE_MASK) | (wdata & WRITE_MASK);

  // store on write, reset to fixed value
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= RESET_VALUE;
    end else if (wr_en) begin
      q <= next_q;
    end
  end

endmodule
